//--- common/brake_sup_defs.svh
// constants for the brake request/answer supervisor
`ifndef BRAKE_SUP_DEFS_SVH
`define BRAKE_SUP_DEFS_SVH

`define CLK_HZ 100000000
`define MISMATCH_TIME_MS 140
`define MISMATCH_CYCLES ((`MISMATCH_TIME_MS * (`CLK_HZ / 1000)))

// apb register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_PINSEL 12'h004
`define ADDR_FUNCS 12'h008
`define ADDR_STOP 12'h00c
`define ADDR_ENERGY 12'h010
`define ADDR_RESIST 12'h014
`define ADDR_STATUS 12'h018
`define ADDR_CLEAR 12'h01c
`define ADDR_IRQ_EN 12'h020
`define ADDR_STATE 12'h024

// ctrl fields
`define CTRL_REQ_BIT 0
`define CTRL_BIG_BIT 1
// pin select fields: request digit [3:0] bits 7:4, answer digit bits 11:8
`define REQ_DIGIT_LSB 4
`define ANS_DIGIT_LSB 8
`define DIGIT_W 4
`define NUM_OUT_PINS 8
`define NUM_IN_PINS 8
`define PIN_NONE 4'h0

// status bits
`define ST_CONFLICT 0
`define ST_MISMATCH 1
`define ST_REJECT 2
`define ST_W 3

`define CNT_W 24
`endif

//--- common/brake_sup_pkg.sv
// types for the brake request/answer supervisor
package brake_sup_pkg;
    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        ST_AGREE = 2'b00,
        ST_DISAGREE = 2'b01,
        ST_FAULT = 2'b10
    } mm_state_t;
endpackage

//--- logic/brake_request_answer_supervisor.sv
// brake request/answer supervisor with apb registers
`timescale 1ns/1ps
`include "brake_sup_defs.svh"

// Summary of operation
// - request output asserted commands braking, deasserted means no braking.
// - functions sharing an output pin drive it as their OR.
// - request mapped onto a shared pin raises the pin conflict alarm.
// - disagreement of request and answer for 0.14 s raises mismatch alarm.
// - request pin mapping allowed only on large variants, rejected otherwise.
// - request pin and answer pin come from digits of mapping parameters.
// - stop method, resistor energy and resistance settings are held.
module brake_request_answer_supervisor (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire brake_sup_pkg::apb_req_t i_apb,
    output brake_sup_pkg::apb_rsp_t o_apb,
    input wire logic [`NUM_IN_PINS-1:0] i_in_pins,
    input wire logic [`NUM_OUT_PINS-1:0] i_other_funcs,
    output logic [`NUM_OUT_PINS-1:0] o_out_pins,
    output logic o_brake_request_out,
    output logic o_request_pin_conflict_alarm,
    output logic o_brake_circuit_mismatch_alarm,
    output logic o_irq
);
    import brake_sup_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic [31:0] pinsel_r;
    logic [`NUM_OUT_PINS-1:0] funcs_r;
    logic [15:0] stop_r;
    logic [15:0] energy_r;
    logic [15:0] resist_r;
    logic [`ST_W-1:0] status_r;
    logic [`ST_W-1:0] irq_en_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    wire [11:0] addr = i_apb.paddr[11:0];
    wire setup = i_apb.psel && !i_apb.penable;
    wire access_ok = i_apb.psel && i_apb.penable && pready_r;
    wire wr = access_ok && i_apb.pwrite;
    wire wr_ctrl = wr && (addr == `ADDR_CTRL);
    wire wr_pinsel = wr && (addr == `ADDR_PINSEL);
    wire wr_funcs = wr && (addr == `ADDR_FUNCS);
    wire wr_stop = wr && (addr == `ADDR_STOP);
    wire wr_energy = wr && (addr == `ADDR_ENERGY);
    wire wr_resist = wr && (addr == `ADDR_RESIST);
    wire wr_clear = wr && (addr == `ADDR_CLEAR);
    wire wr_irq_en = wr && (addr == `ADDR_IRQ_EN);
    wire addr_hit = (addr[1:0] == 2'h0) && (addr <= `ADDR_STATE) && (i_apb.paddr[31:12] == 20'h0);

    // ------------------------------------------------------------
    // pin mapping
    // ------------------------------------------------------------
    wire [`DIGIT_W-1:0] req_digit = pinsel_r[`REQ_DIGIT_LSB +: `DIGIT_W];
    wire [`DIGIT_W-1:0] ans_digit = pinsel_r[`ANS_DIGIT_LSB +: `DIGIT_W];
    wire big_variant = ctrl_r[`CTRL_BIG_BIT];
    // digit 0 means unallocated; digit n selects pin n-1
    wire req_digit_valid = (req_digit != `PIN_NONE) && (req_digit <= `DIGIT_W'(`NUM_OUT_PINS));
    wire ans_digit_valid = (ans_digit != `PIN_NONE) && (ans_digit <= `DIGIT_W'(`NUM_IN_PINS));
    wire req_mapped = req_digit_valid && big_variant;
    wire map_rejected = req_digit_valid && !big_variant;
    wire [2:0] req_idx = 3'(req_digit - `DIGIT_W'(1));
    wire [2:0] ans_idx = 3'(ans_digit - `DIGIT_W'(1));

    wire brake_cmd = ctrl_r[`CTRL_REQ_BIT];
    // functions from elsewhere in the device share the terminals with the register ones
    wire [`NUM_OUT_PINS-1:0] other_vec = funcs_r | i_other_funcs;

    // one-hot pin select, per terminal so the OR and the clash test share it
    wire [`NUM_OUT_PINS-1:0] req_sel;
    wire [`NUM_OUT_PINS-1:0] req_vec;
    wire [`NUM_OUT_PINS-1:0] clash_vec;
    for (genvar p = 0; p < `NUM_OUT_PINS; p++) begin : g_pin
        assign req_sel[p] = req_mapped && (req_idx == 3'(p));
        assign req_vec[p] = req_sel[p] && brake_cmd;
        assign clash_vec[p] = req_sel[p] && other_vec[p];
    end
    wire [`NUM_OUT_PINS-1:0] out_nxt = other_vec | req_vec;
    wire conflict = |clash_vec;

    // answer closed (high) = not braking, so agreement is request == !answer
    wire answer_braking = ans_digit_valid ? !i_in_pins[ans_idx] : 1'b0;
    wire disagree = req_mapped && (brake_cmd != answer_braking);

    // ------------------------------------------------------------
    // mismatch timer
    // ------------------------------------------------------------
    mm_state_t mm_state_r;
    mm_state_t mm_state_nxt;
    logic [`CNT_W-1:0] mm_cnt_r;
    logic [`CNT_W-1:0] mm_cnt_nxt;
    wire mm_expired = (mm_cnt_r == `CNT_W'(`MISMATCH_CYCLES - 1));

    always_comb begin
        mm_state_nxt = mm_state_r;
        mm_cnt_nxt = mm_cnt_r;
        unique case (mm_state_r)
            ST_AGREE: begin
                mm_cnt_nxt = '0;
                if (disagree) begin
                    mm_state_nxt = ST_DISAGREE;
                end
            end
            ST_DISAGREE: begin
                if (!disagree) begin
                    mm_state_nxt = ST_AGREE;
                    mm_cnt_nxt = '0;
                end else if (mm_expired) begin
                    mm_state_nxt = ST_FAULT;
                end else begin
                    mm_cnt_nxt = mm_cnt_r + `CNT_W'(1);
                end
            end
            ST_FAULT: begin
                // stays until disagreement clears so the event fires once per episode
                if (!disagree) begin
                    mm_state_nxt = ST_AGREE;
                end
            end
            default: begin
                mm_state_nxt = ST_AGREE;
                mm_cnt_nxt = '0;
            end
        endcase
    end

    wire mismatch_evt = (mm_state_r == ST_DISAGREE) && disagree && mm_expired;

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    logic conflict_d_r;
    wire [`ST_W-1:0] evt_vec = {map_rejected, mismatch_evt, conflict && !conflict_d_r};
    wire [`ST_W-1:0] clr_vec = wr_clear ? i_apb.pwdata[`ST_W-1:0] : '0;
    // set beats a clear landing in the same cycle
    wire [`ST_W-1:0] status_nxt = (status_r & ~clr_vec) | evt_vec;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        unique case (addr)
            `ADDR_CTRL: rd_val = {30'h0, ctrl_r};
            `ADDR_PINSEL: rd_val = pinsel_r;
            `ADDR_FUNCS: rd_val = {24'h0, funcs_r};
            `ADDR_STOP: rd_val = {16'h0, stop_r};
            `ADDR_ENERGY: rd_val = {16'h0, energy_r};
            `ADDR_RESIST: rd_val = {16'h0, resist_r};
            `ADDR_STATUS: rd_val = {29'h0, status_r};
            `ADDR_IRQ_EN: rd_val = {29'h0, irq_en_r};
            `ADDR_STATE: rd_val = {20'h0, 2'(mm_state_r), o_out_pins, disagree, map_rejected};
            default: rd_val = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // apb slave: no wait state, ready in the first access cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !addr_hit;
        end
    end

    // read data latched in setup, so the mux sees a quiet address
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata_r <= '0;
        end else if (setup && !i_apb.pwrite) begin
            prdata_r <= addr_hit ? rd_val : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= '0;
        end else if (wr_ctrl) begin
            ctrl_r <= i_apb.pwdata[1:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pinsel_r <= '0;
        end else if (wr_pinsel) begin
            pinsel_r <= i_apb.pwdata;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            funcs_r <= '0;
        end else if (wr_funcs) begin
            funcs_r <= i_apb.pwdata[`NUM_OUT_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stop_r <= '0;
        end else if (wr_stop) begin
            stop_r <= i_apb.pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            energy_r <= '0;
        end else if (wr_energy) begin
            energy_r <= i_apb.pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            resist_r <= '0;
        end else if (wr_resist) begin
            resist_r <= i_apb.pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_en_r <= '0;
        end else if (wr_irq_en) begin
            irq_en_r <= i_apb.pwdata[`ST_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // supervisor state and outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mm_state_r <= ST_AGREE;
            mm_cnt_r <= '0;
        end else begin
            mm_state_r <= mm_state_nxt;
            mm_cnt_r <= mm_cnt_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            status_r <= '0;
            conflict_d_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            conflict_d_r <= conflict;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_out_pins <= '0;
            o_brake_request_out <= 1'b0;
            o_request_pin_conflict_alarm <= 1'b0;
            o_brake_circuit_mismatch_alarm <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_out_pins <= out_nxt;
            o_brake_request_out <= req_mapped && brake_cmd;
            o_request_pin_conflict_alarm <= conflict;
            o_brake_circuit_mismatch_alarm <= (mm_state_nxt == ST_FAULT);
            o_irq <= |(status_nxt & irq_en_r);
        end
    end

    assign o_apb.prdata = prdata_r;
    assign o_apb.pready = pready_r;
    assign o_apb.pslverr = pslverr_r;
endmodule

//--- test/brake_sup_properties.sv
// port assertions for the brake supervisor
`timescale 1ns/1ps
`include "brake_sup_defs.svh"
module brake_sup_properties (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire brake_sup_pkg::apb_req_t i_apb,
    input wire brake_sup_pkg::apb_rsp_t o_apb,
    input wire logic [`NUM_IN_PINS-1:0] i_in_pins,
    input wire logic [`NUM_OUT_PINS-1:0] i_other_funcs,
    input wire logic [`NUM_OUT_PINS-1:0] o_out_pins,
    input wire logic o_brake_request_out,
    input wire logic o_request_pin_conflict_alarm,
    input wire logic o_brake_circuit_mismatch_alarm,
    input wire logic o_irq
);
    import brake_sup_pkg::*;
    localparam logic [23:0] FAULT_CYC = 24'd14000000;
    logic [23:0] up_r;
    wire wr_done = i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // saturating age since reset: no fault can be older
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) up_r <= 24'h0;
        else if (up_r != 24'hffffff) up_r <= up_r + 24'h1;
    end
    property p_ready_once; i_apb.psel && !i_apb.penable |=> o_apb.pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("no ready after setup");
    property p_ready_access; o_apb.pready |-> i_apb.psel && i_apb.penable; endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    property p_err_zero;
        o_apb.pready && !i_apb.pwrite && i_apb.paddr > 32'h24 |-> o_apb.pslverr && o_apb.prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped read not refused");
    property p_req_pin; o_brake_request_out |-> o_out_pins != 8'h0; endproperty
    a_req_pin: assert property (p_req_pin) else $error("request not on a pin");
    property p_req_wr; $changed(o_brake_request_out) |-> $past(wr_done, 2); endproperty
    a_req_wr: assert property (p_req_wr) else $error("request moved without write");
    property p_conf_wr;
        $changed(o_request_pin_conflict_alarm) |->
            $past(wr_done) || $past(wr_done, 2) || $past(i_other_funcs) != $past(i_other_funcs, 2);
    endproperty
    a_conf_wr: assert property (p_conf_wr) else $error("conflict moved without write");
    property p_irq_fall; $fell(o_irq) |-> $past(wr_done) || $past(wr_done, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_fault_late; o_brake_circuit_mismatch_alarm |-> up_r >= FAULT_CYC; endproperty
    a_fault_late: assert property (p_fault_late) else $error("mismatch alarm too early");
endmodule

//--- test/brake_contactor_model.sv
// relay and contactor model answering the brake request
`timescale 1ns/1ps
module brake_contactor_model #(
    parameter int ON_DLY = 40,
    parameter int OFF_DLY = 90
) (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_stuck,
    output logic o_ans
);
    int cnt_r = 0;
    logic state_r = 1'b0;
    // stuck models a welded contactor
    always_ff @(posedge i_clk) begin
        if (i_stuck || i_req == state_r) begin
            cnt_r <= 0;
        end else if (cnt_r >= (i_req ? ON_DLY : OFF_DLY)) begin
            state_r <= i_req;
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
    assign o_ans = !state_r;
endmodule

//--- test/tb_brake_request_answer_supervisor.sv
// self-checking bench for the brake supervisor
`timescale 1ns/1ps
`include "brake_sup_defs.svh"
module tb_brake_request_answer_supervisor;
    import brake_sup_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    apb_req_t apb = '0;
    apb_rsp_t rsp;
    logic [7:0] in_pins = 8'h0;
    logic [7:0] out_pins, f, g;
    logic [7:0] other = 8'h0;
    logic req, conflict, fault, irq, ans, err;
    logic stuck = 1'b0;
    logic [31:0] rd, seed = 32'd99;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    initial forever #5 clk = ~clk;
    brake_request_answer_supervisor i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_apb(apb), .o_apb(rsp),
        .i_in_pins(in_pins), .i_other_funcs(other), .o_out_pins(out_pins), .o_brake_request_out(req),
        .o_request_pin_conflict_alarm(conflict), .o_brake_circuit_mismatch_alarm(fault), .o_irq(irq));
    brake_contactor_model i_model (.i_clk(clk), .i_req(req), .i_stuck(stuck), .o_ans(ans));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] a, b;
        a = s ^ (s << 13);
        b = a ^ (a >> 17);
        return b ^ (b << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        apb <= '{paddr: {20'h0, a}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // answer on pin 0, other terminals random
    always @(posedge clk) begin
        in_pins <= {seed[7:1], ans};
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            $display("[ERR] %0t timeout", $time);
            error_cnt++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            bus(1'b1, 12'(`ADDR_STOP + 4 * i), seed & (i == 0 ? 32'h3 : 32'hffff));
            bus(1'b0, 12'(`ADDR_STOP + 4 * i), 32'h0);
            chk(rd, seed & (i == 0 ? 32'h3 : 32'hffff));
        end
        bus(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        $display("settings test done");
        bus(1'b1, `ADDR_PINSEL, 32'h110);
        bus(1'b1, `ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({req, out_pins}, 9'h0);
        bus(1'b0, `ADDR_STATUS, 32'h0);
        chk(rd[2], 1'b1);
        $display("reject test done");
        for (int d = 1; d <= 8; d++) begin
            seed = xs(seed);
            f = seed[7:0];
            g = seed[15:8];
            other <= g;
            bus(1'b1, `ADDR_FUNCS, {24'h0, f});
            bus(1'b1, `ADDR_PINSEL, 32'h100 | (32'(d) << 4));
            bus(1'b1, `ADDR_CTRL, 32'h3);
            repeat (3) @(posedge clk);
            chk(req, 1'b1);
            chk(out_pins, f | g | (8'h1 << (d - 1)));
            chk(conflict, f[d - 1] | g[d - 1]);
            bus(1'b1, `ADDR_CTRL, 32'h2);
            repeat (3) @(posedge clk);
            chk({req, out_pins}, {1'b0, f | g});
        end
        other <= 8'h0;
        $display("mapping test done");
        bus(1'b1, `ADDR_FUNCS, 32'h1);
        bus(1'b1, `ADDR_PINSEL, 32'h110);
        bus(1'b1, `ADDR_IRQ_EN, 32'h1);
        repeat (3) @(posedge clk);
        chk({conflict, irq}, 2'b11);
        bus(1'b1, `ADDR_IRQ_EN, 32'h0);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        bus(1'b1, `ADDR_FUNCS, 32'h0);
        bus(1'b1, `ADDR_IRQ_EN, 32'h1);
        bus(1'b1, `ADDR_CLEAR, 32'h7);
        repeat (3) @(posedge clk);
        chk({conflict, irq}, 2'b00);
        $display("interrupt test done");
        stuck <= 1'b1;
        bus(1'b1, `ADDR_CTRL, 32'h3);
        repeat (30000) @(posedge clk);
        bus(1'b0, `ADDR_STATE, 32'h0);
        chk({fault, rd[1]}, 2'b01);
        chk(rd[11:10], 2'b01);
        stuck <= 1'b0;
        repeat (200) @(posedge clk);
        bus(1'b0, `ADDR_STATE, 32'h0);
        chk({fault, rd[1]}, 2'b00);
        chk(rd[11:10], 2'b00);
        bus(1'b1, `ADDR_CTRL, 32'h2);
        repeat (300) @(posedge clk);
        chk({fault, req, ans}, 3'b001);
        $display("mismatch test done");
        final_report();
    end
endmodule
bind brake_request_answer_supervisor brake_sup_properties i_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_apb(i_apb), .o_apb(o_apb), .i_in_pins(i_in_pins), .i_other_funcs(i_other_funcs),
    .o_out_pins(o_out_pins), .o_brake_request_out(o_brake_request_out),
    .o_request_pin_conflict_alarm(o_request_pin_conflict_alarm),
    .o_brake_circuit_mismatch_alarm(o_brake_circuit_mismatch_alarm), .o_irq(o_irq));
